// File: rtl/nmq_map.svh
/*
  register offsets, field positions, opcodes and reset values of the
  native maximum address query block.
  assumes inclusion by the package, the design file and the testbench.
*/
`ifndef NMQ_MAP_SVH
`define NMQ_MAP_SVH
// apb byte addresses, one aligned word each
`define OFS_ERROR      12'h000
`define OFS_COUNT      12'h004
`define OFS_ADDR_LOW   12'h008
`define OFS_ADDR_MID   12'h00c
`define OFS_ADDR_HIGH  12'h010
`define OFS_DEVICE     12'h014
`define OFS_STATUS     12'h018
`define OFS_FEATURES   12'h01c
`define OFS_COMMAND    12'h020
`define OFS_DEV_CTRL   12'h024
`define OFS_CONFIG     12'h028
// command codes
`define OPC_NATIVE28   8'hf8
`define OPC_NATIVE48   8'h27
// bit positions
`define BIT_BUSY       7
`define BIT_READY      6
`define BIT_FAULT      5
`define BIT_DREQ       3
`define BIT_ERR        0
`define BIT_ABORT      2
`define BIT_DRV_SEL    4
`define BIT_LBA_MODE   6
`define BIT_HOB        7
// configuration bits
`define CFG_PROTECTED  0
`define CFG_ADDR48     1
`define CFG_REMOVABLE  2
`define CFG_FAULT      3
`define CFG_UNABLE     4
`define CFG_RESET      8'h03
// limits and reset values
`define CAP28          48'h00000fffffff
`define NATIVE_MAX_DEF 48'h0000ffffffff
`define STATUS_RESET   8'h40
`define BUSY_CYCLES    2'h2
`endif

// File: rtl/nmq_pkg.sv
/*
  types of the native maximum address query block.
  assumes nmq_map.svh is on the include path.
*/
`include "nmq_map.svh"
package nmq_pkg;
  typedef enum logic [1:0] {st_idle, st_busy, st_done} cmd_state_t;
  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] prev;
  } tf_pair_t;
endpackage : nmq_pkg

// File: rtl/native_max_address_query.sv
/*
  device-side task-file registers over apb answering the two native maximum
  address query commands, 28-bit and 48-bit.
  assumes a single apb master on clk; reset_n asynchronous active low.
*/
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "nmq_map.svh"
module native_max_address_query
  import nmq_pkg::*;
#(
  parameter logic [47:0] NATIVE_MAX = `NATIVE_MAX_DEF
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  cmd_state_t  state_r;
  tf_pair_t    count_r, low_r, mid_r, high_r, feat_r;
  logic [7:0]  device_r, status_r, error_r, devctl_r, config_r, opcode_r;
  logic [1:0]  busy_cnt_r;
  logic        aborted_r;
  logic [47:0] result_r;

  wire logic setup  = psel && !penable;
  wire logic access = psel && penable && pready;
  wire logic wr     = access && pwrite;
  wire logic cmd_wr = wr && hit(paddr, `OFS_COMMAND) && state_r == st_idle;
  wire logic high_order_byte_select    = devctl_r[`BIT_HOB];
  wire logic mapped = hit(paddr, `OFS_ERROR) || hit(paddr, `OFS_COUNT) ||
                      hit(paddr, `OFS_ADDR_LOW) || hit(paddr, `OFS_ADDR_MID) ||
                      hit(paddr, `OFS_ADDR_HIGH) || hit(paddr, `OFS_DEVICE) ||
                      hit(paddr, `OFS_STATUS) || hit(paddr, `OFS_FEATURES) ||
                      hit(paddr, `OFS_COMMAND) || hit(paddr, `OFS_DEV_CTRL) ||
                      hit(paddr, `OFS_CONFIG);
  // writes to the task file while busy are dropped, as on a real drive
  wire logic tf_wr  = wr && state_r == st_idle;

  // decode of the query and its support conditions
  wire logic is28   = opcode_r == `OPC_NATIVE28;
  wire logic is48   = opcode_r == `OPC_NATIVE48;
  wire logic sup28  = config_r[`CFG_PROTECTED] &&
                      !config_r[`CFG_REMOVABLE];
  wire logic sup48  = sup28 && config_r[`CFG_ADDR48];
  wire logic ok     = (is28 && sup28 && !config_r[`CFG_UNABLE]) ||
                      (is48 && sup48);
  // 28-bit form saturates once 48-bit addressing is in play
  wire logic [47:0] val28 = (config_r[`CFG_ADDR48] && NATIVE_MAX > `CAP28) ?
                            `CAP28 : NATIVE_MAX;
  // lowered address limits are never consulted
  wire logic [47:0] val = is28 ? val28 : NATIVE_MAX;

  // command sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= st_idle;
      busy_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        st_idle: if (cmd_wr) begin
          state_r    <= st_busy;
          busy_cnt_r <= `BUSY_CYCLES;
        end
        st_busy: if (busy_cnt_r == 2'h0) begin
          state_r <= st_done;
        end else begin
          busy_cnt_r <= busy_cnt_r - 2'h1;
        end
        st_done: state_r <= st_idle;
        default: state_r <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opcode_r  <= 8'h00;
      aborted_r <= 1'b0;
    end else if (cmd_wr) begin
      opcode_r <= pwdata[7:0];
    end else if (state_r == st_busy && busy_cnt_r == 2'h0) begin
      aborted_r <= !ok;
    end
  end

  // result frozen at the end of busy so a config write in the completion
  // cycle cannot tear the address that the host reads back
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_r <= 48'h0;
    end else if (state_r == st_busy && busy_cnt_r == 2'h0 && ok) begin
      result_r <= val;
    end
  end

  // task-file pairs keep current and previous byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      feat_r  <= '0;
      low_r   <= '0;
      mid_r   <= '0;
      high_r  <= '0;
    end else if (state_r == st_done && !aborted_r) begin
      low_r  <= '{cur: result_r[7:0],   prev: result_r[31:24]};
      mid_r  <= '{cur: result_r[15:8],  prev: result_r[39:32]};
      high_r <= '{cur: result_r[23:16], prev: result_r[47:40]};
    end else if (tf_wr) begin
      if (hit(paddr, `OFS_COUNT))
        count_r <= '{cur: pwdata[7:0], prev: count_r.cur};
      if (hit(paddr, `OFS_FEATURES))
        feat_r <= '{cur: pwdata[7:0], prev: feat_r.cur};
      if (hit(paddr, `OFS_ADDR_LOW))
        low_r <= '{cur: pwdata[7:0], prev: low_r.cur};
      if (hit(paddr, `OFS_ADDR_MID))
        mid_r <= '{cur: pwdata[7:0], prev: mid_r.cur};
      if (hit(paddr, `OFS_ADDR_HIGH))
        high_r <= '{cur: pwdata[7:0], prev: high_r.cur};
    end
  end

  // device register: drive select bit 4 is never touched by completion
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      device_r <= 8'h00;
    end else if (state_r == st_done && !aborted_r && is28) begin
      device_r <= {device_r[7:4], result_r[27:24]};
    end else if (tf_wr && hit(paddr, `OFS_DEVICE)) begin
      device_r <= pwdata[7:0];
    end
  end

  // device control stays writable while busy so hob can flip at any time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      devctl_r <= 8'h00;
    end else if (wr && hit(paddr, `OFS_DEV_CTRL)) begin
      devctl_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_r <= `CFG_RESET;
    end else if (wr && hit(paddr, `OFS_CONFIG)) begin
      config_r <= pwdata[7:0];
    end
  end

  // status: busy set on acceptance, cleared on completion
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= `STATUS_RESET;
    end else if (cmd_wr) begin
      status_r[`BIT_BUSY] <= 1'b1;
    end else if (state_r == st_done) begin
      status_r <= 8'h00;
      status_r[`BIT_READY] <= 1'b1;
      status_r[`BIT_FAULT] <= is48 && config_r[`CFG_FAULT];
      status_r[`BIT_ERR]   <= aborted_r;
    end
  end

  // error register is written only at completion; abort is its sole source
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      error_r <= 8'h00;
    end else if (state_r == st_done) begin
      error_r <= 8'h00;
      error_r[`BIT_ABORT] <= aborted_r;
    end
  end

  // hob picks the byte that was written before the most recent one
  function automatic logic [7:0] pick(input tf_pair_t p, input logic h);
    pick = h ? p.prev : p.cur;
  endfunction : pick

  // apb read mux; the byte is caught in the setup cycle
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (1'b1)
      hit(paddr, `OFS_ERROR):     rd_byte = error_r;
      hit(paddr, `OFS_COUNT):     rd_byte = pick(count_r, high_order_byte_select);
      hit(paddr, `OFS_ADDR_LOW):  rd_byte = pick(low_r, high_order_byte_select);
      hit(paddr, `OFS_ADDR_MID):  rd_byte = pick(mid_r, high_order_byte_select);
      hit(paddr, `OFS_ADDR_HIGH): rd_byte = pick(high_r, high_order_byte_select);
      hit(paddr, `OFS_DEVICE):    rd_byte = device_r;
      hit(paddr, `OFS_STATUS):    rd_byte = status_r;
      hit(paddr, `OFS_DEV_CTRL):  rd_byte = devctl_r;
      hit(paddr, `OFS_CONFIG):    rd_byte = config_r;
      default:                    rd_byte = 8'h00;
    endcase
  end

  // registered answer: data latched in setup, ready one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup && !pwrite ? {24'h0, rd_byte} : 32'h0;
    end
  end

  a_busy_done: assert property (
    @(posedge clk) disable iff (!reset_n)
    cmd_wr |=> status_r[`BIT_BUSY] [*4] ##1 !status_r[`BIT_BUSY])
    else $error("busy not held for the command");

  a_busy_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    cmd_wr |=> status_r[`BIT_BUSY] && state_r == st_busy)
    else $error("busy not raised on acceptance");

  a_busy_len: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_busy |-> busy_cnt_r <= `BUSY_CYCLES)
    else $error("busy counter out of range");

  a_done_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done |=> state_r == st_idle && !status_r[`BIT_BUSY])
    else $error("completion did not release busy");

  a_opc_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r != st_idle |=> $stable(opcode_r))
    else $error("opcode changed while a command runs");

  a_done_ready: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done |=> status_r[`BIT_READY] && !status_r[`BIT_DREQ])
    else $error("ready not set at completion");

  a_fault_28: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is28 |=> !status_r[`BIT_FAULT])
    else $error("fault left set by the 28-bit query");

  a_fault_48: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is48 && !aborted_r |=>
      status_r[`BIT_FAULT] == $past(config_r[`CFG_FAULT]))
    else $error("fault flag does not show the device fault");

  a_ok_clean: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && !aborted_r |=>
      !status_r[`BIT_ERR] && error_r == 8'h00)
    else $error("error reported on a good completion");

  a_abort_err: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done |=> error_r[`BIT_ABORT] == status_r[`BIT_ERR])
    else $error("error flag does not follow abort");

  a_abort_only: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done |=> (error_r & ~(8'h01 << `BIT_ABORT)) == 8'h00)
    else $error("unexpected error bits");

  a_abort_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && aborted_r |=>
      low_r == $past(low_r) && high_r == $past(high_r))
    else $error("abort changed the address registers");

  a_unsup_abort: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is48 && !sup48 |=> error_r[`BIT_ABORT])
    else $error("unsupported query not aborted");

  a_cap_28: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is28 && !aborted_r |=>
      {device_r[3:0], high_r.cur, mid_r.cur, low_r.cur} == val28[27:0])
    else $error("28-bit result wrong");

  a_cap_sat: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is28 && !aborted_r && config_r[`CFG_ADDR48] &&
      NATIVE_MAX > `CAP28 |=>
      {device_r[3:0], high_r.cur, mid_r.cur, low_r.cur} == 28'(`CAP28))
    else $error("28-bit result not saturated");

  a_ext_lo: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is48 && !aborted_r |=>
      {high_r.cur, mid_r.cur, low_r.cur} == NATIVE_MAX[23:0])
    else $error("48-bit low bytes wrong");

  a_ext_hi: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is48 && !aborted_r |=>
      {high_r.prev, mid_r.prev, low_r.prev} == NATIVE_MAX[47:24])
    else $error("48-bit high bytes wrong");

  a_prev_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    tf_wr && hit(paddr, `OFS_ADDR_LOW) && state_r != st_done |=>
      low_r.prev == $past(low_r.cur))
    else $error("previous byte lost");

  a_dev_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done |=>
      device_r[`BIT_DRV_SEL] == $past(device_r[`BIT_DRV_SEL]))
    else $error("drive select changed by completion");

  a_dev_ext: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == st_done && is48 |=> device_r == $past(device_r))
    else $error("48-bit query touched the device register");

  a_hob_sel: assert property (
    @(posedge clk) disable iff (!reset_n)
    access && !pwrite && hit(paddr, `OFS_ADDR_HIGH) |->
      prdata[7:0] == $past(pick(high_r, high_order_byte_select)))
    else $error("high address byte not chosen by hob");

  a_slverr_rdy: assert property (
    @(posedge clk) disable iff (!reset_n)
    pslverr |-> pready)
    else $error("slave error without ready");

  a_rd_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    !pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");

  a_rdy_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("ready held beyond one cycle");

  c_ok28: cover property (@(posedge clk) disable iff (!reset_n)
    state_r == st_done && is28 && !aborted_r);

  c_ok48: cover property (@(posedge clk) disable iff (!reset_n)
    state_r == st_done && is48 && !aborted_r);

  c_abort: cover property (@(posedge clk) disable iff (!reset_n)
    state_r == st_done && aborted_r);

  c_hob_read: cover property (@(posedge clk) disable iff (!reset_n)
    access && !pwrite && high_order_byte_select);

  c_fault48: cover property (@(posedge clk) disable iff (!reset_n)
    state_r == st_done && is48 && config_r[`CFG_FAULT]);

endmodule : native_max_address_query

// File: test/host_model.sv
/*
  behavioural host controller model: an apb master with one transfer task.
  assumes a single registered-answer apb slave on clk.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // one idle cycle between transfers keeps every strobe single-driven
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [7:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench watchdog ends this wait
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show the inverse so stale values never pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : host_model

// File: test/native_max_address_query_tb.sv
/*
  self-checking bench of the native maximum address query block.
  assumes host_model as apb master and the register map header.
*/
`timescale 1ns/1ps
`include "nmq_map.svh"
module native_max_address_query_tb;
  import nmq_pkg::*;
  localparam logic [47:0] NMAX = 48'h3a5c96e127b4;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_errors;
  int          checked;
  logic [16:0] notes[$];
  logic [16:0] note;
  logic [31:0] seed;
  logic [7:0]  rd;
  logic [7:0]  a0;
  logic [7:0]  a1;
  logic [7:0]  cfgs[6] = '{8'h07, 8'h07, 8'h13, 8'h01, 8'h00, 8'h03};
  logic [7:0]  opcs[6] = '{8'hf8, 8'h27, 8'hf8, 8'h27, 8'hf8, 8'h20};

  host_model host_u (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready));
  native_max_address_query #(.NATIVE_MAX(NMAX)) dut_u (.clk(clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // a read notes {slverr, mask, value}; the monitor compares at the answer
  task automatic rdc(input logic [11:0] a, input logic [7:0] e,
                     input logic [7:0] m = 8'hff, input logic s = 1'b0);
    notes.push_back({s, m, e});
    host_u.xfer(1'b0, a, 32'h0, rd);
  endtask : rdc

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, {24'h0, d}, rd);
  endtask : wr

  task automatic cmd(input logic [7:0] cfg, dev, opc, st, er);
    int k;
    wr(`OFS_CONFIG, cfg);
    wr(`OFS_DEVICE, dev);
    wr(`OFS_COMMAND, opc);
    rdc(`OFS_STATUS, 8'h80, 8'h80);
    k = 0;
    while (rd[7] !== 1'b0 && k < 20) begin
      rdc(`OFS_STATUS, 8'h00, 8'h00);
      k++;
    end
    if (k == 20)
      check("busy poll", 8'h01, 8'h00);
    rdc(`OFS_STATUS, st);
    rdc(`OFS_ERROR, er);
  endtask : cmd

  task automatic chk28(input logic [27:0] v, input logic [7:0] dev);
    rdc(`OFS_ADDR_LOW, v[7:0]);
    rdc(`OFS_ADDR_MID, v[15:8]);
    rdc(`OFS_ADDR_HIGH, v[23:16]);
    rdc(`OFS_DEVICE, {dev[7:4], v[27:24]});
  endtask : chk28

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (notes.size() == 0)
        check("read note", 8'h01, 8'h00);
      else begin
        note = notes.pop_front();
        check("prdata", prdata[7:0] & note[15:8],
              note[7:0] & note[15:8]);
        check("pslverr", {7'h0, pslverr}, {7'h0, note[16]});
      end
    end
  end

  initial begin
    #100000;
    n_errors++;
    finish_test();
  end

  initial begin
    reset_n = 1'b0;
    n_errors = 0;
    checked = 0;
    seed = 32'hd478bd03;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rdc(`OFS_STATUS, `STATUS_RESET);
    rdc(`OFS_CONFIG, `CFG_RESET);
    rdc(`OFS_ERROR, 8'h00);
    rdc(12'h02c, 8'h00, 8'h00, 1'b1);
    $display("test reset_values done");
    seed = lfsr(seed);
    a0 = seed[7:0];
    seed = lfsr(seed);
    a1 = seed[15:8];
    wr(`OFS_ADDR_LOW, a0);
    wr(`OFS_ADDR_LOW, a1);
    wr(`OFS_COUNT, a1);
    wr(`OFS_COUNT, a0);
    wr(`OFS_FEATURES, a0);
    rdc(`OFS_ADDR_LOW, a1);
    rdc(`OFS_COUNT, a0);
    rdc(`OFS_FEATURES, 8'h00);
    wr(`OFS_DEV_CTRL, 8'h80);
    rdc(`OFS_ADDR_LOW, a0);
    rdc(`OFS_COUNT, a1);
    wr(`OFS_DEV_CTRL, 8'h00);
    $display("test register_pairs done");
    cmd(8'h03, 8'h50, `OPC_NATIVE28, 8'h40, 8'h00);
    chk28(28'hfffffff, 8'h50);
    cmd(8'h01, 8'h40, `OPC_NATIVE28, 8'h40, 8'h00);
    chk28(NMAX[27:0], 8'h40);
    $display("test query28 done");
    cmd(8'h0b, 8'h50, `OPC_NATIVE48, 8'h60, 8'h00);
    for (int h = 0; h < 2; h++) begin
      wr(`OFS_DEV_CTRL, 8'(h << 7));
      for (int r = 0; r < 3; r++)
        rdc(`OFS_ADDR_LOW + 12'(4 * r), NMAX[24 * h + 8 * r +: 8]);
    end
    wr(`OFS_DEV_CTRL, 8'h00);
    rdc(`OFS_DEVICE, 8'h50);
    cmd(8'h03, 8'h40, `OPC_NATIVE48, 8'h40, 8'h00);
    $display("test query48 done");
    for (int i = 0; i < 6; i++) begin
      cmd(cfgs[i], 8'h40 | 8'(i[0] << 4), opcs[i], 8'h41, 8'h04);
      rdc(`OFS_DEVICE, 8'h40 | 8'(i[0] << 4));
      rdc(`OFS_ADDR_LOW, NMAX[7:0]);
    end
    $display("test aborts done");
    finish_test();
  end
endmodule : native_max_address_query_tb
